// ==== imrs_baud_gen.sv ====
// baud period timer: counts down from the reload value, pulses expired at zero
// assumes load is a one-cycle pulse from the sequencer; period is reload+1 cycles
`timescale 1ns/1ps
module imrs_baud_gen #(
  parameter int BRG_W = imrs_pkg::BRG_W_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control from the sequencer
  imrs_brg_if.gen brg
);

  logic [BRG_W-1:0] count_reg;
  logic running_reg;
  logic expired_reg;

  generate
    if (BRG_W < imrs_pkg::BRG_W_MIN || BRG_W > imrs_pkg::BRG_W_MAX) begin : g_bad_width
      $error("baud counter width out of range");
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
      running_reg <= 1'h0;
      expired_reg <= 1'h0;
    end else if (brg.load) begin
      count_reg <= brg.reloadValue;
      running_reg <= 1'h1;
      expired_reg <= 1'h0;
    end else if (running_reg && count_reg == '0) begin
      running_reg <= 1'h0;
      expired_reg <= 1'h1;
    end else if (running_reg) begin
      count_reg <= count_reg - 1'b1;
      expired_reg <= 1'h0;
    end else begin
      expired_reg <= 1'h0;
    end
  end

  assign brg.expired = expired_reg;

  property p_expire_once;
    @(posedge clk) disable iff (!arst_n)
    expired_reg |=> !expired_reg;
  endproperty
  a_expire_once: assert property (p_expire_once) else $error("expired pulse longer than one cycle");

endmodule

// ==== imrs_brg_if.sv ====
// carrier between the sequencer and its baud period timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface imrs_brg_if #(
  parameter int BRG_W = imrs_pkg::BRG_W_DEFAULT
);
  logic load;
  logic [BRG_W-1:0] reloadValue;
  logic expired;

  modport ctrl (output load, output reloadValue, input expired);
  modport gen (input load, input reloadValue, output expired);
endinterface

// ==== imrs_bus_model.sv ====
// far side of the bus: pull-ups plus other parties that may pull either line low
// assumes the lines follow the enables combinationally, as the sequencer expects
`timescale 1ns/1ps
module imrs_bus_model (
  // enables from the master
  input wire logic sclOe_n,
  input wire logic sdaOe_n,
  // other parties pulling low
  input wire logic sclPull,
  input wire logic sdaPull,
  // resolved line levels
  output logic sclIn,
  output logic sdaIn
);
  // wired-and with a pull-up: a released line reads high
  assign sclIn = sclOe_n & ~sclPull;
  assign sdaIn = sdaOe_n & ~sdaPull;
endmodule

// ==== imrs_pkg.sv ====
// constants and types shared by the repeated start generator and its baud timer
// assumes a single system clock and an asynchronous active-low reset
package imrs_pkg;

  // default width of the baud period counter
  localparam int BRG_W_DEFAULT = 8;
  localparam int BRG_W_MIN = 2;
  localparam int BRG_W_MAX = 16;

  // reset values of the bus and status flops
  localparam logic PIN_OE_N_RESET = 1'h1;
  localparam logic PIN_OUT_VALUE = 1'h0;
  localparam logic FLAG_RESET = 1'h0;
  localparam logic LINE_IDLE_LEVEL = 1'h1;

  // sequence states, gray coded along the normal path up to ST_SDA_LOW; the return to ST_IDLE flips all three bits
  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_SCL_LOW   = 3'h1,
    ST_SDA_REL   = 3'h3,
    ST_SCL_REL   = 3'h2,
    ST_HOLD_HIGH = 3'h6,
    ST_SDA_LOW   = 3'h7
  } imrs_state_t;

endpackage

// ==== imrs_repeated_start.sv ====
// repeated start generator for the master side of a two-wire serial bus
// assumes scl/sda inputs are synchronous samples of the open-drain lines
// Summary of operation
// R1: start only on request while master idle
// R2: request during other bus activity is ignored
// R3: drive SCL low, load timer once low
// R4: release SDA for one baud period
// R5: on timeout with SDA high, release SCL
// R6: SCL high: reload, both high one period
// R7: SDA low one period, then SCL low
// R8: end: clear request, no reload, SDA low
// R9: flag start condition seen on lines
// R10: interrupt flag only after timer timeout
// R11: collision if SDA low as SCL rises
// R12: collision if SCL low before SDA driven
// R13: on collision abort, release lines, report
`timescale 1ns/1ps
module imrs_repeated_start #(
  parameter int BRG_W = imrs_pkg::BRG_W_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // software side
  input wire logic requestWrite,
  input wire logic masterBusy,
  input wire logic [BRG_W-1:0] baudPeriod,
  input wire logic irqClear,
  input wire logic startClear,
  input wire logic collisionClear,
  output logic repeatStartRequest,
  output logic startDetected,
  output logic serialPortIrqFlag,
  output logic busCollision,
  // bus lines, open drain
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe_n,
  output logic sdaOut,
  output logic sdaOe_n
);

  imrs_pkg::imrs_state_t state_reg;
  logic sclPrev_reg;
  logic sdaPrev_reg;
  logic load_reg;
  logic collide;
  logic finish;
  logic reqAccept;

  imrs_brg_if #(.BRG_W(BRG_W)) brg ();

  imrs_baud_gen #(.BRG_W(BRG_W)) u_baud (
    .clk(clk),
    .arst_n(arst_n),
    .brg(brg)
  );

  assign brg.load = load_reg;
  assign brg.reloadValue = baudPeriod;

  // sda falling while scl high
  function automatic logic startCondition(input logic sdaWas, input logic sdaNow, input logic sclNow);
    startCondition = sdaWas && !sdaNow && sclNow;
  endfunction

  assign reqAccept = requestWrite && !masterBusy && state_reg == imrs_pkg::ST_IDLE && !repeatStartRequest;

  // collision terms per state
  always_comb begin
    collide = 1'h0;
    unique case (state_reg)
      imrs_pkg::ST_SDA_REL: collide = brg.expired && !sdaIn;
      imrs_pkg::ST_SCL_REL: collide = sclIn && !sclPrev_reg && !sdaIn; // R11
      imrs_pkg::ST_HOLD_HIGH: collide = !sclIn; // R12
      imrs_pkg::ST_SDA_LOW: collide = !sclIn; // R12
      imrs_pkg::ST_IDLE, imrs_pkg::ST_SCL_LOW: collide = 1'h0;
    endcase
  end

  assign finish = state_reg == imrs_pkg::ST_SDA_LOW && brg.expired && !collide;

  // line history for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclPrev_reg <= imrs_pkg::LINE_IDLE_LEVEL;
      sdaPrev_reg <= imrs_pkg::LINE_IDLE_LEVEL;
    end else begin
      sclPrev_reg <= sclIn;
      sdaPrev_reg <= sdaIn;
    end
  end

  // request bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      repeatStartRequest <= imrs_pkg::FLAG_RESET;
    end else if (reqAccept) begin
      repeatStartRequest <= 1'h1; // R1 R2
    end else if (finish || collide) begin
      repeatStartRequest <= 1'h0; // R8 R13
    end
  end

  // sequencer with timer load and pin drive
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= imrs_pkg::ST_IDLE;
      load_reg <= 1'h0;
      sclOe_n <= imrs_pkg::PIN_OE_N_RESET;
      sdaOe_n <= imrs_pkg::PIN_OE_N_RESET;
    end else begin
      load_reg <= 1'h0;
      if (collide) begin
        state_reg <= imrs_pkg::ST_IDLE; // R13
        sclOe_n <= 1'h1;
        sdaOe_n <= 1'h1;
      end else begin
        unique case (state_reg)
          imrs_pkg::ST_IDLE: begin
            if (reqAccept) begin
              state_reg <= imrs_pkg::ST_SCL_LOW;
              sclOe_n <= 1'h0; // R3
            end
          end
          imrs_pkg::ST_SCL_LOW: begin
            if (!sclIn) begin
              state_reg <= imrs_pkg::ST_SDA_REL;
              load_reg <= 1'h1; // R3
              sdaOe_n <= 1'h1; // R4
            end
          end
          imrs_pkg::ST_SDA_REL: begin
            if (brg.expired && sdaIn) begin
              state_reg <= imrs_pkg::ST_SCL_REL;
              sclOe_n <= 1'h1; // R5
            end
          end
          imrs_pkg::ST_SCL_REL: begin
            if (sclIn) begin
              state_reg <= imrs_pkg::ST_HOLD_HIGH;
              load_reg <= 1'h1; // R6
            end
          end
          imrs_pkg::ST_HOLD_HIGH: begin
            if (brg.expired) begin
              state_reg <= imrs_pkg::ST_SDA_LOW;
              load_reg <= 1'h1; // R7
              sdaOe_n <= 1'h0;
            end
          end
          imrs_pkg::ST_SDA_LOW: begin
            if (brg.expired) begin
              state_reg <= imrs_pkg::ST_IDLE;
              sclOe_n <= 1'h0; // R7 R8
            end
          end
        endcase
      end
    end
  end

  // pin output levels: open drain, only ever low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclOut <= imrs_pkg::PIN_OUT_VALUE;
      sdaOut <= imrs_pkg::PIN_OUT_VALUE;
    end else begin
      sclOut <= imrs_pkg::PIN_OUT_VALUE;
      sdaOut <= imrs_pkg::PIN_OUT_VALUE;
    end
  end

  // status flags, set wins over clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      startDetected <= imrs_pkg::FLAG_RESET;
    end else if (startCondition(sdaPrev_reg, sdaIn, sclIn)) begin
      startDetected <= 1'h1; // R9
    end else if (startClear) begin
      startDetected <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serialPortIrqFlag <= imrs_pkg::FLAG_RESET;
    end else if (finish) begin
      serialPortIrqFlag <= 1'h1; // R10
    end else if (irqClear) begin
      serialPortIrqFlag <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busCollision <= imrs_pkg::FLAG_RESET;
    end else if (collide) begin
      busCollision <= 1'h1; // R13
    end else if (collisionClear) begin
      busCollision <= 1'h0;
    end
  end

  property p_req_idle;
    @(posedge clk) disable iff (!arst_n)
    $rose(repeatStartRequest) |-> $past(state_reg == imrs_pkg::ST_IDLE && !masterBusy);
  endproperty
  a_req_idle: assert property (p_req_idle) else $error("request accepted while not idle"); // R1

  property p_busy_ignored;
    @(posedge clk) disable iff (!arst_n)
    (requestWrite && masterBusy && state_reg == imrs_pkg::ST_IDLE && !repeatStartRequest)
      |=> (state_reg == imrs_pkg::ST_IDLE && !repeatStartRequest && $stable(sclOe_n));
  endproperty
  a_busy_ignored: assert property (p_busy_ignored) else $error("busy request took effect"); // R2

  property p_scl_low_load;
    @(posedge clk) disable iff (!arst_n)
    (state_reg == imrs_pkg::ST_SCL_LOW && !sclIn) |=> (load_reg && sdaOe_n && !sclOe_n);
  endproperty
  a_scl_low_load: assert property (p_scl_low_load) else $error("timer not loaded after scl low"); // R3

  property p_sda_released;
    @(posedge clk) disable iff (!arst_n)
    $rose(state_reg == imrs_pkg::ST_SDA_REL) |-> (sdaOe_n && load_reg) ##1 (sdaOe_n && !brg.expired);
  endproperty
  a_sda_released: assert property (p_sda_released) else $error("sda not released for a period"); // R4

  property p_scl_release;
    @(posedge clk) disable iff (!arst_n)
    (state_reg == imrs_pkg::ST_SDA_REL && brg.expired && sdaIn) |=> (sclOe_n && state_reg == imrs_pkg::ST_SCL_REL);
  endproperty
  a_scl_release: assert property (p_scl_release) else $error("scl not released on timeout"); // R5

  property p_hold_high;
    @(posedge clk) disable iff (!arst_n)
    (state_reg == imrs_pkg::ST_SCL_REL && sclIn && !collide) |=> (load_reg && sclOe_n && sdaOe_n);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("hold period not started"); // R6

  property p_sda_low;
    @(posedge clk) disable iff (!arst_n)
    (state_reg == imrs_pkg::ST_SDA_LOW) |-> (!sdaOe_n && sclOe_n);
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda low phase wrong"); // R7

  property p_finish;
    @(posedge clk) disable iff (!arst_n)
    finish |=> (!repeatStartRequest && !sdaOe_n && !sclOe_n && !load_reg && serialPortIrqFlag);
  endproperty
  a_finish: assert property (p_finish) else $error("end of sequence wrong"); // R8

  property p_start_seen;
    @(posedge clk) disable iff (!arst_n)
    startCondition(sdaPrev_reg, sdaIn, sclIn) |=> startDetected;
  endproperty
  a_start_seen: assert property (p_start_seen) else $error("start condition not flagged"); // R9

  property p_irq_after_timeout;
    @(posedge clk) disable iff (!arst_n)
    $rose(serialPortIrqFlag) |-> $past(brg.expired);
  endproperty
  a_irq_after_timeout: assert property (p_irq_after_timeout) else $error("irq before timeout"); // R10

  property p_col_rise;
    @(posedge clk) disable iff (!arst_n)
    (state_reg == imrs_pkg::ST_SCL_REL && sclIn && !sclPrev_reg && !sdaIn) |=> busCollision;
  endproperty
  a_col_rise: assert property (p_col_rise) else $error("sda low on scl rise not flagged"); // R11

  property p_col_scl;
    @(posedge clk) disable iff (!arst_n)
    (state_reg == imrs_pkg::ST_HOLD_HIGH && !sclIn) |=> (busCollision && state_reg == imrs_pkg::ST_IDLE);
  endproperty
  a_col_scl: assert property (p_col_scl) else $error("early scl low not flagged"); // R12

  property p_abort;
    @(posedge clk) disable iff (!arst_n)
    collide |=> (sclOe_n && sdaOe_n && !repeatStartRequest && state_reg == imrs_pkg::ST_IDLE);
  endproperty
  a_abort: assert property (p_abort) else $error("collision did not abort"); // R13

endmodule

// ==== imrs_repeated_start_tb_top.sv ====
// self-checking bench for the repeated start generator
// assumes the open-drain bus model and a 10 MHz clock
`timescale 1ns/1ps
module imrs_repeated_start_tb_top;
  logic clk = 0, arst_n = 0, requestWrite = 0, masterBusy = 0;
  logic irqClear = 0, startClear = 0, collisionClear = 0, sclPull = 0, sdaPull = 0;
  logic [7:0] baudPeriod = 8'h03;
  logic repeatStartRequest, startDetected, serialPortIrqFlag, busCollision;
  logic sclIn, sdaIn, sclOut, sclOe_n, sdaOut, sdaOe_n;
  int error_cnt = 0, n_checks = 0, seed = 32'h66c8006f, p, n;

  imrs_repeated_start #(.BRG_W(8)) dut (.clk(clk), .arst_n(arst_n), .requestWrite(requestWrite),
    .masterBusy(masterBusy), .baudPeriod(baudPeriod), .irqClear(irqClear), .startClear(startClear),
    .collisionClear(collisionClear), .repeatStartRequest(repeatStartRequest),
    .startDetected(startDetected), .serialPortIrqFlag(serialPortIrqFlag), .busCollision(busCollision),
    .sclIn(sclIn), .sdaIn(sdaIn), .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n));
  imrs_bus_model bus (.sclOe_n(sclOe_n), .sdaOe_n(sdaOe_n), .sclPull(sclPull), .sdaPull(sdaPull),
    .sclIn(sclIn), .sdaIn(sdaIn));

  initial begin
    forever #50 clk = ~clk;
  end

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task check1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task check_len(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  // one-cycle pulse on a software strobe
  task strobe(input int which);
    @(posedge clk);
    case (which)
      0: requestWrite <= 1'h1;
      1: irqClear <= 1'h1;
      2: startClear <= 1'h1;
      default: collisionClear <= 1'h1;
    endcase
    @(posedge clk);
    {requestWrite, irqClear, startClear, collisionClear} <= 4'h0;
  endtask

  // wait for an enable pair, then count how long it lasts
  task phase(input logic sc, input logic sd, output int len);
    int k;
    k = 0;
    len = 0;
    @(negedge clk);
    while ({sclOe_n, sdaOe_n} !== {sc, sd} && k < 100) begin
      k++;
      @(negedge clk);
    end
    if (k >= 100) begin
      error_cnt++;
      close_out();
    end
    while ({sclOe_n, sdaOe_n} === {sc, sd} && len < 100) begin
      len++;
      @(negedge clk);
    end
  endtask

  task wait_coll;
    int k;
    k = 0;
    while (busCollision !== 1'h1 && k < 200) begin
      k++;
      @(negedge clk);
    end
    if (k >= 200) begin
      error_cnt++;
      close_out();
    end
    check1(sclOe_n, 1'h1);
    check1(sdaOe_n, 1'h1);
    check1(repeatStartRequest, 1'h0);
    @(posedge clk);
    {sclPull, sdaPull} <= 2'h0;
    strobe(3);
    @(negedge clk);
    check1(busCollision, 1'h0);
  endtask

  task run_normal;
    @(posedge clk);
    baudPeriod <= 8'(2 + {$random(seed)} % 5);
    @(posedge clk);
    p = int'(baudPeriod) + 1;
    strobe(0);
    phase(1'h0, 1'h1, n);
    check_len(n, p, p + 3);
    phase(1'h1, 1'h1, n);
    check_len(n, p, p + 3);
    check1(startDetected, 1'h0);
    check1(serialPortIrqFlag, 1'h0);
    phase(1'h1, 1'h0, n);
    check_len(n, p, p + 3);
    check1(repeatStartRequest, 1'h0);
    check1(serialPortIrqFlag, 1'h1);
    check1(startDetected, 1'h1);
    check1(busCollision, 1'h0);
    repeat (p + 3) @(negedge clk);
    check1(sclOe_n, 1'h0);
    check1(sdaOe_n, 1'h0);
    check1(sclOut, 1'h0);
    check1(sdaOut, 1'h0);
    strobe(1);
    strobe(2);
    @(negedge clk);
    check1(serialPortIrqFlag, 1'h0);
    $display("normal sequence done, period %0d", p);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    masterBusy <= 1'h1;
    strobe(0);
    repeat (6) @(negedge clk);
    check1(repeatStartRequest, 1'h0);
    check1(sclOe_n, 1'h1);
    @(posedge clk);
    masterBusy <= 1'h0;
    $display("busy refusal done");
    repeat (3) run_normal();
    strobe(0);
    @(posedge clk);
    sdaPull <= 1'h1;
    wait_coll();
    $display("data collision done");
    // sda pulled low just after scl is released, before the scl rise is sampled
    strobe(0);
    phase(1'h0, 1'h1, n);
    check_len(n, p, p + 3);
    sdaPull <= 1'h1;
    wait_coll();
    check1(startDetected, 1'h1);
    strobe(2);
    @(negedge clk);
    check1(startDetected, 1'h0);
    $display("rising clock collision done");
    strobe(0);
    phase(1'h0, 1'h1, n);
    repeat (2) @(posedge clk);
    sclPull <= 1'h1;
    wait_coll();
    $display("clock collision done");
    run_normal();
    close_out();
  end
endmodule
